// file: mpc_carrier_gen.v
// mpc_carrier_gen.v: carrier counter with prescale/postscale enable divider.
// assumes one clock, asynchronous active-high reset, settings from registers.
`timescale 1ns/1ps
`include "mpc_consts.vh"

module mpc_carrier_gen #(
    parameter CNT_W = 11
) (
    // clock and reset
    input  wire             clock,
    input  wire             sys_rst,
    // settings
    input  wire             enable,
    input  wire [1:0]       shape,
    input  wire [1:0]       prescale,
    input  wire [2:0]       postscale,
    input  wire [CNT_W-1:0] period,
    // carrier state
    output reg  [CNT_W-1:0] count_r,
    output reg              periodStart_r
);
    reg  [1:0]       preCnt_r;
    reg  [2:0]       postCnt_r;
    reg              countDown_r;
    wire [1:0]       preMax  = (prescale == 2'h0) ? 2'h0 : prescale - 2'h1;
    wire [2:0]       postMax = (postscale == 3'h0) ? 3'h0 : postscale - 3'h1;
    wire             preTick = (preCnt_r == preMax);
    wire             tick    = preTick && (postCnt_r == postMax);
    wire [CNT_W-1:0] topVal  = (period == {CNT_W{1'b0}}) ? {CNT_W{1'b0}} : period - 1'b1;

    // ------------------------------------------------------------------------
    // divider and counter
    // ------------------------------------------------------------------------
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            preCnt_r      <= 2'h0;
            postCnt_r     <= 3'h0;
            count_r       <= {CNT_W{1'b0}};
            countDown_r   <= 1'b0;
            periodStart_r <= 1'b0;
        end else if (!enable) begin
            preCnt_r      <= 2'h0;
            postCnt_r     <= 3'h0;
            count_r       <= {CNT_W{1'b0}};
            countDown_r   <= 1'b0;
            periodStart_r <= 1'b0;
        end else begin
            periodStart_r <= 1'b0;
            preCnt_r      <= preTick ? 2'h0 : preCnt_r + 2'h1;
            if (preTick)
                postCnt_r <= (postCnt_r == postMax) ? 3'h0 : postCnt_r + 3'h1;
            if (tick) begin
                case (shape)
                    `MPC_SHAPE_DOWN: begin
                        // period ticks per cycle, no factor of two
                        if (count_r == {CNT_W{1'b0}}) begin
                            count_r       <= topVal;
                            periodStart_r <= 1'b1;
                        end else begin
                            count_r <= count_r - 1'b1;
                        end
                    end
                    `MPC_SHAPE_UPDOWN: begin
                        // 2*period ticks per cycle
                        if (!countDown_r) begin
                            if (count_r == topVal)
                                countDown_r <= 1'b1;
                            else
                                count_r <= count_r + 1'b1;
                        end else if (count_r == {CNT_W{1'b0}}) begin
                            countDown_r   <= 1'b0;
                            periodStart_r <= 1'b1;
                        end else begin
                            count_r <= count_r - 1'b1;
                        end
                    end
                    default: begin
                        if (count_r >= topVal) begin
                            count_r       <= {CNT_W{1'b0}};
                            periodStart_r <= 1'b1;
                        end else begin
                            count_r <= count_r + 1'b1;
                        end
                    end
                endcase
            end
        end
    end
endmodule // mpc_carrier_gen

// file: mpc_consts.vh
// mpc_consts.vh: register offsets, field positions, reset values and encodings
// for the motor pwm carrier / square-wave block.
// assumes inclusion by bare name from the design files.
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define MPC_OFS_CTRL      8'h00
`define MPC_OFS_PERIOD    8'h04
`define MPC_OFS_DUTYH     8'h08
`define MPC_OFS_DUTYL     8'h0C
`define MPC_OFS_HALL      8'h10
`define MPC_OFS_STATUS    8'h14
`define MPC_OFS_UTAB0     8'h20
`define MPC_ADDR_W        8

// ----------------------------------------------------------------------------
// carrier_control_reg fields
// ----------------------------------------------------------------------------
`define MPC_CTL_SHAPE_LO  0
`define MPC_CTL_SHAPE_HI  1
`define MPC_CTL_PRE_LO    2
`define MPC_CTL_PRE_HI    3
`define MPC_CTL_POST_LO   4
`define MPC_CTL_POST_HI   6
`define MPC_CTL_DIR       7
`define MPC_CTL_HALLSRC   8
`define MPC_CTL_USERTAB   9
`define MPC_CTL_EN        10
`define MPC_CTL_W         11

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define MPC_RST_CTRL      11'h0F5
`define MPC_RST_PERIOD    11'h3E8
`define MPC_RST_DUTY      11'h000

// ----------------------------------------------------------------------------
// carrier shapes
// ----------------------------------------------------------------------------
`define MPC_SHAPE_UP      2'h0
`define MPC_SHAPE_DOWN    2'h1
`define MPC_SHAPE_UPDOWN  2'h2

// ----------------------------------------------------------------------------
// table entry codes: 2 bits per gate output
// ----------------------------------------------------------------------------
`define MPC_ENT_ZERO      2'h0
`define MPC_ENT_ONE       2'h1
`define MPC_ENT_PWM       2'h2
`define MPC_ENT_INV       2'h3

`endif

// file: mpc_hall_model.sv
// mpc_hall_model.sv: hall sensor model for the square-wave engine.
// assumes the bench sets the rotor code; pins are unrelated to the clock.
`timescale 1ns/1ps
module mpc_hall_model (
    // rotor position
    input  logic [2:0] code,
    // sensor pins
    output logic [2:0] hallIn
);
    // sensors switch with unequal skew, so transient codes reach the engine
    initial hallIn = 3'h0;
    always @(code[0]) hallIn[0] <= #1.1 code[0];
    always @(code[1]) hallIn[1] <= #2.3 code[1];
    always @(code[2]) hallIn[2] <= #3.7 code[2];
endmodule // mpc_hall_model

// file: mpc_pwm_engine.v
// mpc_pwm_engine.v: carrier and square-wave commutation engine with an
// axi4-lite register slave. assumes hall inputs are asynchronous pins.
`timescale 1ns/1ps
`include "mpc_consts.vh"

// How it works
// - engine holds carrier and square stages; sine and mux are outside
// - carrier sets shape and frequency for generators
// - shape select chooses up, down, up-down
// - prescale, postscale, period divide system clock
// - up-down frequency includes extra factor two
// - up or down frequency has no doubling
// - default table maps hall, direction to gates
// - hall code from pins or register
// - direction bit selects different pattern set
// - hall 000 and 111 drive all low with the default table; the software table sets its own entries for them
// - direction one commutation patterns
// - software table can replace default patterns
// - hall mode takes position from input pins
// - pwm, inverse, or constant per entry
// - duty is eleven bits from two registers
module mpc_pwm_engine #(
    parameter CNT_W = 11
) (
    // clock and reset
    input  wire        clock,
    input  wire        sys_rst,
    // axi4-lite write address / data / response
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // hall sensor pins
    input  wire [2:0]  hallIn,
    // gate outputs: high side u,v,w and low side x,y,z
    output reg  [2:0]  gateHigh_r,
    output reg  [2:0]  gateLow_r
);
    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg [`MPC_CTL_W-1:0] ctrl_r;
    reg [CNT_W-1:0]      period_r;
    reg [7:0]            dutyHigh_r;
    reg [2:0]            dutyLow_r;
    reg [2:0]            hallReg_r;
    reg [11:0]           userTab_r [0:15];
    reg [2:0]            hallMeta_r;
    reg [2:0]            hallSync_r;
    reg                  pwm_r;
    reg [1:0]            wrErr_r;
    integer              i;

    wire [CNT_W-1:0] count;
    wire             periodStart;
    wire [1:0]       shape     = ctrl_r[`MPC_CTL_SHAPE_HI:`MPC_CTL_SHAPE_LO];
    wire             direction = ctrl_r[`MPC_CTL_DIR];
    wire [10:0]      duty      = {dutyHigh_r, dutyLow_r};

    // ------------------------------------------------------------------------
    // carrier generator
    // ------------------------------------------------------------------------
    // sine generator and output mux are outside this block; this engine
    // provides the carrier and the square-wave path only
    mpc_carrier_gen #(
        .CNT_W (CNT_W)
    ) uCarrier (
        .clock         (clock),
        .sys_rst       (sys_rst),
        .enable        (ctrl_r[`MPC_CTL_EN]),
        .shape         (shape),
        .prescale      (ctrl_r[`MPC_CTL_PRE_HI:`MPC_CTL_PRE_LO]),
        .postscale     (ctrl_r[`MPC_CTL_POST_HI:`MPC_CTL_POST_LO]),
        .period        (period_r),
        .count_r       (count),
        .periodStart_r (periodStart)
    );

    // ------------------------------------------------------------------------
    // default commutation table: {u,v,w,x,y,z} entries, 2 bits each
    // ------------------------------------------------------------------------
    function [11:0] defaultEntry;
        input       dir;
        input [2:0] code;
        begin
            defaultEntry = 12'h000;
            if (dir) begin
                case (code)
                    3'h1: defaultEntry = {`MPC_ENT_PWM, `MPC_ENT_ZERO, `MPC_ENT_ZERO,
                                          `MPC_ENT_INV, `MPC_ENT_ONE, `MPC_ENT_ZERO};
                    3'h5: defaultEntry = {`MPC_ENT_PWM, `MPC_ENT_ZERO, `MPC_ENT_ZERO,
                                          `MPC_ENT_INV, `MPC_ENT_ZERO, `MPC_ENT_ONE};
                    3'h3: defaultEntry = {`MPC_ENT_ZERO, `MPC_ENT_ZERO, `MPC_ENT_PWM,
                                          `MPC_ENT_ZERO, `MPC_ENT_ONE, `MPC_ENT_INV};
                    3'h2: defaultEntry = {`MPC_ENT_ZERO, `MPC_ENT_ZERO, `MPC_ENT_PWM,
                                          `MPC_ENT_ONE, `MPC_ENT_ZERO, `MPC_ENT_INV};
                    3'h6: defaultEntry = {`MPC_ENT_ZERO, `MPC_ENT_PWM, `MPC_ENT_ZERO,
                                          `MPC_ENT_ONE, `MPC_ENT_INV, `MPC_ENT_ZERO};
                    3'h4: defaultEntry = {`MPC_ENT_ZERO, `MPC_ENT_PWM, `MPC_ENT_ZERO,
                                          `MPC_ENT_ZERO, `MPC_ENT_INV, `MPC_ENT_ONE};
                    default: defaultEntry = 12'h000;
                endcase
            end else begin
                case (code)
                    3'h5: defaultEntry = {`MPC_ENT_ZERO, `MPC_ENT_ZERO, `MPC_ENT_PWM,
                                          `MPC_ENT_ONE, `MPC_ENT_ZERO, `MPC_ENT_INV};
                    3'h4: defaultEntry = {`MPC_ENT_ZERO, `MPC_ENT_ZERO, `MPC_ENT_PWM,
                                          `MPC_ENT_ZERO, `MPC_ENT_ONE, `MPC_ENT_INV};
                    3'h6: defaultEntry = {`MPC_ENT_PWM, `MPC_ENT_ZERO, `MPC_ENT_ZERO,
                                          `MPC_ENT_INV, `MPC_ENT_ONE, `MPC_ENT_ZERO};
                    3'h2: defaultEntry = {`MPC_ENT_PWM, `MPC_ENT_ZERO, `MPC_ENT_ZERO,
                                          `MPC_ENT_INV, `MPC_ENT_ZERO, `MPC_ENT_ONE};
                    3'h3: defaultEntry = {`MPC_ENT_ZERO, `MPC_ENT_PWM, `MPC_ENT_ZERO,
                                          `MPC_ENT_ZERO, `MPC_ENT_INV, `MPC_ENT_ONE};
                    3'h1: defaultEntry = {`MPC_ENT_ZERO, `MPC_ENT_PWM, `MPC_ENT_ZERO,
                                          `MPC_ENT_ONE, `MPC_ENT_INV, `MPC_ENT_ZERO};
                    default: defaultEntry = 12'h000;
                endcase
            end
        end
    endfunction

    function entryLevel;
        input [1:0] ent;
        input       pwm;
        begin
            case (ent)
                `MPC_ENT_ONE: entryLevel = 1'b1;
                `MPC_ENT_PWM: entryLevel = pwm;
                `MPC_ENT_INV: entryLevel = ~pwm;
                default:      entryLevel = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // hall source and pattern selection
    // ------------------------------------------------------------------------
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hallMeta_r <= 3'h0;
            hallSync_r <= 3'h0;
        end else begin
            hallMeta_r <= hallIn;
            hallSync_r <= hallMeta_r;
        end
    end

    wire [2:0]  hallCode = ctrl_r[`MPC_CTL_HALLSRC] ? hallSync_r : hallReg_r;
    wire [11:0] entry    = ctrl_r[`MPC_CTL_USERTAB] ? userTab_r[{direction, hallCode}]
                                                    : defaultEntry(direction, hallCode);

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_r      <= 1'b0;
            gateHigh_r <= 3'h0;
            gateLow_r  <= 3'h0;
        end else begin
            pwm_r      <= ctrl_r[`MPC_CTL_EN] && (count < duty);
            gateHigh_r <= {entryLevel(entry[11:10], pwm_r), entryLevel(entry[9:8], pwm_r),
                           entryLevel(entry[7:6], pwm_r)};
            gateLow_r  <= {entryLevel(entry[5:4], pwm_r), entryLevel(entry[3:2], pwm_r),
                           entryLevel(entry[1:0], pwm_r)};
        end
    end

    // ------------------------------------------------------------------------
    // axi4-lite write: both channels taken together, response after
    // ------------------------------------------------------------------------
    wire wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wrGo;
    assign s_axi_wready  = wrGo;
    assign s_axi_bresp   = wrErr_r;
    wire   wrUser = (s_axi_awaddr[7:6] == 2'h0) && s_axi_awaddr[5];

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r       <= `MPC_RST_CTRL;
            period_r     <= `MPC_RST_PERIOD;
            dutyHigh_r   <= 8'h00;
            dutyLow_r    <= 3'h0;
            hallReg_r    <= 3'h0;
            s_axi_bvalid <= 1'b0;
            wrErr_r      <= 2'h0;
            for (i = 0; i < 16; i = i + 1)
                userTab_r[i] <= 12'h000;
        end else begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wrGo) begin
                s_axi_bvalid <= 1'b1;
                wrErr_r      <= 2'h0;
                if (wrUser) begin
                    if (s_axi_wstrb[0])
                        userTab_r[s_axi_awaddr[5:2]][7:0] <= s_axi_wdata[7:0];
                    if (s_axi_wstrb[1])
                        userTab_r[s_axi_awaddr[5:2]][11:8] <= s_axi_wdata[11:8];
                end else begin
                    case ({s_axi_awaddr[7:2], 2'h0})
                        `MPC_OFS_CTRL: begin
                            if (s_axi_wstrb[0])
                                ctrl_r[7:0] <= s_axi_wdata[7:0];
                            if (s_axi_wstrb[1])
                                ctrl_r[10:8] <= s_axi_wdata[10:8];
                        end
                        `MPC_OFS_PERIOD: begin
                            if (s_axi_wstrb[0])
                                period_r[7:0] <= s_axi_wdata[7:0];
                            if (s_axi_wstrb[1])
                                period_r[10:8] <= s_axi_wdata[10:8];
                        end
                        `MPC_OFS_DUTYH: if (s_axi_wstrb[0]) dutyHigh_r <= s_axi_wdata[7:0];
                        `MPC_OFS_DUTYL: if (s_axi_wstrb[0]) dutyLow_r <= s_axi_wdata[2:0];
                        `MPC_OFS_HALL:  if (s_axi_wstrb[0]) hallReg_r <= s_axi_wdata[2:0];
                        `MPC_OFS_STATUS: wrErr_r <= 2'h0;
                        default: wrErr_r <= 2'h2;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // axi4-lite read
    // ------------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end else begin
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                s_axi_rdata  <= 32'h00000000;
                if ((s_axi_araddr[7:6] == 2'h0) && s_axi_araddr[5]) begin
                    s_axi_rdata <= {20'h00000, userTab_r[s_axi_araddr[5:2]]};
                end else begin
                    case ({s_axi_araddr[7:2], 2'h0})
                        `MPC_OFS_CTRL:   s_axi_rdata <= {21'h000000, ctrl_r};
                        `MPC_OFS_PERIOD: s_axi_rdata <= {21'h000000, period_r};
                        `MPC_OFS_DUTYH:  s_axi_rdata <= {24'h000000, dutyHigh_r};
                        `MPC_OFS_DUTYL:  s_axi_rdata <= {29'h00000000, dutyLow_r};
                        `MPC_OFS_HALL:   s_axi_rdata <= {29'h00000000, hallReg_r};
                        `MPC_OFS_STATUS: s_axi_rdata <= {10'h000, periodStart, pwm_r, hallCode,
                                                         gateHigh_r, gateLow_r, count};
                        default:         s_axi_rresp <= 2'h2;
                    endcase
                end
            end
        end
    end
endmodule // mpc_pwm_engine

// file: mpc_pwm_engine_chk.sv
// mpc_pwm_engine_chk.sv: port-level checker for the pwm carrier / square-wave engine.
// assumes binding to mpc_pwm_engine; sees only its ports.
`timescale 1ns/1ps
module mpc_pwm_engine_chk #(
    parameter CNT_W = 11
) (
    input logic        clock,
    input logic        sys_rst,
    input logic [7:0]  s_axi_awaddr,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [2:0]  gateHigh_r,
    input logic [2:0]  gateLow_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------------
    // bus and gate properties
    // ------------------------------------------------------------------
    property p_wr_bad; s_axi_awvalid && s_axi_awready && s_axi_awaddr >= 8'h40 |=> s_axi_bvalid && s_axi_bresp == 2'h2; endproperty
    property p_wr_ok; s_axi_awvalid && s_axi_awready && s_axi_awaddr < 8'h18 |=> s_axi_bvalid && s_axi_bresp == 2'h0; endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    property p_no_aw; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_rd_bad; s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h40 |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_no_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
    property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid [*2]; endproperty
    property p_rst_gates; $fell(sys_rst) |-> gateHigh_r == 3'h0 && gateLow_r == 3'h0; endproperty
    a_wr_bad: assert property (p_wr_bad) else $error("unmapped write not refused");
    a_wr_ok: assert property (p_wr_ok) else $error("mapped write not answered okay");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    a_no_aw: assert property (p_no_aw) else $error("write taken while response pending");
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
    a_r_hold: assert property (p_r_hold) else $error("read data changed before taken");
    a_no_ar: assert property (p_no_ar) else $error("read taken while data pending");
    a_r_once: assert property (p_r_once) else $error("read answered twice");
    a_rst_gates: assert property (p_rst_gates) else $error("gates active after reset");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_gate: cover property (gateHigh_r != 3'h0);
endmodule // mpc_pwm_engine_chk

// file: tb.sv
// tb.sv: self-checking bench for the pwm carrier / square-wave engine.
// assumes axi4-lite register access and a hall sensor model on the pins.
`timescale 1ns/1ps
module tb;
    logic        clock, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  hallIn, hallCode, gateHigh_r, gateLow_r, e;
    logic [65:0] expQ[$];
    integer      num_errors, tests_run, d, p, c, t0;
    mpc_pwm_engine u_dut (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hallIn,
        .gateHigh_r, .gateLow_r);
    mpc_hall_model u_hall (.code(hallCode), .hallIn);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ------------------------------------------------------------------
    // bus master, monitor and checks
    // ------------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] r);
        expQ.push_back({r, 64'h0});
        @(posedge clock);
        s_axi_awaddr <= a; s_axi_wdata <= dt; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do @(posedge clock); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0; s_axi_wvalid <= 1'b0;
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic [1:0] r);
        expQ.push_back({r, m, x & m});
        @(posedge clock);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    task cmp(input logic [65:0] g);
        logic [65:0] x;
        x = expQ.pop_front();
        tests_run++;
        if ({g[65:64], g[31:0] & x[63:32]} !== {x[65:64], x[31:0]}) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    always @(posedge clock) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) cmp({s_axi_bresp, 64'h0});
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) cmp({s_axi_rresp, 32'h0, s_axi_rdata});
    end
    function automatic logic [5:0] tab(input logic [3:0] k);
        // pwm phase one-hot {u,v,w}, constant-on low side one-hot {x,y,z}
        case (k)
            4'h1, 4'hE: tab = 6'h14;
            4'h2, 4'hD: tab = 6'h21;
            4'h3, 4'hC: tab = 6'h11;
            4'h4, 4'hB: tab = 6'h0A;
            4'h5, 4'hA: tab = 6'h0C;
            4'h6, 4'h9: tab = 6'h22;
            default:    tab = 6'h00;
        endcase
    endfunction
    task gate(input logic dr, input logic [2:0] cd, input logic pw, input logic src);
        logic [5:0] t;
        t = tab({dr, cd});
        if (src) begin
            @(posedge clock);
            hallCode <= cd;
            repeat (8) @(posedge clock);
        end else begin
            wr(8'h10, {29'h0, cd}, 2'h0);
            repeat (2) @(posedge clock);
        end
        rd(8'h14, 32'h1F800, {15'h0, pw ? t[5:3] : 3'h0, (pw ? 3'h0 : t[5:3]) | t[2:0], 11'h0}, 2'h0);
    endtask
    task per(input logic [31:0] ctl, input logic [10:0] prd, input integer x);
        wr(8'h04, {21'h0, prd}, 2'h0);
        wr(8'h00, ctl, 2'h0);
        repeat (2) @(posedge gateHigh_r[2]);
        t0 = $time;
        @(posedge gateHigh_r[2]);
        tests_run++;
        if (($time - t0) / 4 != x) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, ($time - t0) / 4, x);
        end
    endtask
    task wrap_up;
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        wrap_up;
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'h6b89; num_errors = 0; tests_run = 0; sys_rst = 1'b1; hallCode = 3'h0;
        s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0; s_axi_awaddr = 8'h0; s_axi_araddr = 8'h0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'h00, 32'h7FF, 32'h0F5, 2'h0);
        rd(8'h04, 32'h7FF, 32'h3E8, 2'h0);
        rd(8'h10, 32'h7, 32'h0, 2'h0);
        rd(8'h40, 32'hFFFFFFFF, 32'h0, 2'h2);
        wr(8'h44, 32'h5, 2'h2);
        $display("test reset_map done");
        repeat (4) begin
            v = $random(seed);
            wr(8'h08, v, 2'h0);
            wr(8'h0C, v >> 8, 2'h0);
            rd(8'h08, 32'hFF, v, 2'h0);
            rd(8'h0C, 32'h7, v >> 8, 2'h0);
        end
        $display("test duty done");
        for (d = 0; d < 2; d++) for (p = 0; p < 2; p++) begin
            wr(8'h08, p ? 32'hFF : 32'h0, 2'h0);
            wr(8'h0C, p ? 32'h7 : 32'h0, 2'h0);
            wr(8'h00, 32'h414 | (d << 7), 2'h0);
            for (c = 0; c < 8; c++) gate(d, c, p, 1'b0);
        end
        $display("test default_table done");
        wr(8'h10, 32'h3, 2'h0);
        wr(8'h00, 32'h694, 2'h0);
        for (p = 0; p < 2; p++) begin
            wr(8'h08, p ? 32'hFF : 32'h0, 2'h0);
            wr(8'h0C, p ? 32'h7 : 32'h0, 2'h0);
            for (c = 0; c < 3; c++) begin
                e = (c == 0) ? 3'h7 : (c == 1) ? {3{p[0]}} : {3{~p[0]}};
                wr(8'h2C, (c == 0) ? 32'h555 : (c == 1) ? 32'hAAA : 32'hFFF, 2'h0);
                repeat (2) @(posedge clock);
                rd(8'h14, 32'h1F800, {15'h0, e, e, 11'h0}, 2'h0);
            end
        end
        $display("test user_table done");
        wr(8'h00, 32'h594, 2'h0);
        repeat (6) begin
            v = $random(seed);
            gate(1'b1, v[2:0], 1'b1, 1'b1);
        end
        $display("test hall_pins done");
        wr(8'h10, 32'h1, 2'h0);
        wr(8'h08, 32'h0, 2'h0);
        wr(8'h0C, 32'h2, 2'h0);
        per(32'h4B8, 11'd5, 30);
        per(32'h495, 11'd7, 7);
        per(32'h4AE, 11'd4, 48);
        per(32'h483, 11'd9, 9);
        $display("test carrier done");
        wrap_up;
    end
endmodule // tb
bind mpc_pwm_engine mpc_pwm_engine_chk #(.CNT_W(CNT_W)) u_chk (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gateHigh_r, .gateLow_r);
